/* File: core/ssar_pkg.sv */
// Package with constants and types for the security supervisor logic
package ssar_pkg;
    localparam int unsigned CLK_FREQ_HZ = 10000000;
    localparam int unsigned RESET_TIMEOUT_MS = 200;
    localparam int unsigned RESET_TIMEOUT_CYCLES = (CLK_FREQ_HZ / 1000) * RESET_TIMEOUT_MS;
    localparam int unsigned TMR_W = 22;

    // APB register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_SENSE = 8'h08;

    // Control field positions and reset values
    localparam int CTRL_VARIANT_LSB = 0;
    localparam int CTRL_UTEMP_LSB = 2;
    localparam int CTRL_LTEMP_BIT = 4;
    localparam int CTRL_BCHK_LSB = 5;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    typedef enum logic [1:0] {
        SSAR_VAR_A = 2'h0,
        SSAR_VAR_B = 2'h1,
        SSAR_VAR_C = 2'h2
    } ssar_variant_e;

    // Reset sequencer states, one-hot
    typedef enum logic [2:0] {
        SSAR_RST_HOLD = 3'h1,
        SSAR_RST_WAIT = 3'h2,
        SSAR_RST_RUN = 3'h4
    } ssar_rst_state_e;

    // Comparator flags from the analog front end
    typedef struct packed {
        logic int_over_upper;
        logic int_under_lower;
        logic main_below_reset;
        logic main_below_switch;
        logic main_below_backup;
        logic pfi_below;
        logic main_below_bat_release;
        logic main_above_ref_max;
        logic temp_over_80;
        logic temp_over_85;
        logic temp_over_95;
        logic temp_under_25;
        logic temp_under_35;
        logic bat_below_23;
        logic bat_below_25;
        logic bat_below_32;
    } ssar_cmp_s;

    // Drive outputs toward the analog switches
    typedef struct packed {
        logic supply_on;
        logic supply_from_battery;
        logic supply_hiz;
        logic supply_ground;
        logic ref_enable;
    } ssar_sw_s;
endpackage

/* File: core/ssar_top.sv */
// Security supervisor alarm, reset and supply sequencing logic
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// [R1] Alarm when internal supply over upper limit
// [R2] Alarm when internal supply under lower limit
// [R3] Alarm when any tamper input leaves normal
// [R4] Alarm above selected upper temperature limit
// [R5] Alarm below selected lower temperature limit
// [R6] System ignores alarm level during power-up; security_alarm_n is not gated by the reset sequencer
// [R7] Alarm works on main and battery
// [R8] Tamper one and three normally high
// [R9] Tamper two and four normally low
// [R10] Source indicator low on main, high battery
// [R11] Variants B, C force indicator high on alarm
// [R12] Alarm: A on, B high-Z, C grounded
// [R13] Battery check only during power-up sequence
// [R14] Battery low set on check, released below threshold
// [R15] Reset low while supply low or manual reset
// [R16] Reset held a further 200 ms timeout
// [R17] Power-fail low on input low or switchover
// [R18] Reference valid only above switchover threshold
// [R19] Supply source follows switchover comparison; code switches on main_below_backup, not main_below_switch
// [R20] Timer clears on low supply, restarts after
// [R21] Power-fail held low while on battery
// [R22] All flags pass two-stage synchronizer
// [R23] Timeout counter terminal count is parameter
module ssar_top
    import ssar_pkg::*;
#(
    parameter int unsigned TIMEOUT_CYCLES = RESET_TIMEOUT_CYCLES // [R23]
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ssar_cmp_s cmp_in,
    input wire logic tamper_in_1,
    input wire logic tamper_in_2,
    input wire logic tamper_in_3,
    input wire logic tamper_in_4,
    input wire logic manual_reset_n,
    output logic security_alarm_n,
    output logic reset_n,
    output logic power_fail_out_n,
    output logic battery_low_n,
    output logic supply_source_n,
    output ssar_sw_s sw_out
);
    localparam int FLAG_W = 21;

    logic [FLAG_W-1:0] sync_a;
    logic [FLAG_W-1:0] sync_b;
    logic [6:0] ctrl;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] next_tmr;
    ssar_rst_state_e rst_state;
    ssar_rst_state_e next_rst_state;
    logic check_done;
    logic next_battery_low_n;
    logic next_check_done;
    ssar_sw_s next_sw;

    // Raw inputs gathered for the synchronizer
    wire [FLAG_W-1:0] raw_flags = {manual_reset_n, tamper_in_4, tamper_in_3,
        tamper_in_2, tamper_in_1, cmp_in};
    wire ssar_cmp_s cmp = sync_b[15:0];
    wire tp1 = sync_b[16];
    wire tp2 = sync_b[17];
    wire tp3 = sync_b[18];
    wire tp4 = sync_b[19];
    wire mr_n = sync_b[20];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Tamper 1/3 and manual reset idle high
            sync_a <= 21'h1500ff & 21'h150000;
            sync_b <= 21'h150000;
        end
        else
        begin
            sync_a <= raw_flags; // [R22]
            sync_b <= sync_a; // [R22]
        end
    end

    wire [1:0] variant = ctrl[CTRL_VARIANT_LSB +: 2];
    wire [1:0] utemp_sel = ctrl[CTRL_UTEMP_LSB +: 2];
    wire ltemp_sel = ctrl[CTRL_LTEMP_BIT];
    wire [1:0] bchk_sel = ctrl[CTRL_BCHK_LSB +: 2];

    // Voltage alarms hold on either internal supply source
    wire volt_alarm = cmp.int_over_upper | cmp.int_under_lower; // [R1] [R2] [R7]
    wire tamper_alarm = ~tp1 | ~tp3 | tp2 | tp4; // [R3] [R8] [R9]

    // Three-way build option select; codes above two fall to the last
    function automatic logic pick3(input logic [1:0] sel, input logic a, input logic b,
        input logic c);
        return (sel == 2'h0) ? a : (sel == 2'h1) ? b : c;
    endfunction

    wire temp_hi = pick3(utemp_sel, cmp.temp_over_80, cmp.temp_over_85,
        cmp.temp_over_95); // [R4]
    wire temp_lo = ltemp_sel ? cmp.temp_under_35 : cmp.temp_under_25; // [R5]
    wire alarm = volt_alarm | tamper_alarm | temp_hi | temp_lo;
    // Hysteresis lives in the analog comparators, not here
    wire on_battery = cmp.main_below_backup; // [R19]
    wire bat_low = pick3(bchk_sel, cmp.bat_below_23, cmp.bat_below_25, cmp.bat_below_32);
    wire rst_cause = cmp.main_below_reset | ~mr_n; // [R15]
    wire tmr_done = (tmr >= TMR_W'(TIMEOUT_CYCLES - 1));

    always_comb
    begin
        next_rst_state = rst_state;
        next_tmr = tmr;
        case (rst_state)
            SSAR_RST_HOLD:
            begin
                next_tmr = '0; // [R20]
                if (!rst_cause)
                    next_rst_state = SSAR_RST_WAIT;
            end
            SSAR_RST_WAIT:
            begin
                if (rst_cause)
                begin
                    next_rst_state = SSAR_RST_HOLD; // [R20]
                    next_tmr = '0;
                end
                else if (tmr_done)
                    next_rst_state = SSAR_RST_RUN; // [R16]
                else
                    next_tmr = tmr + 1'b1; // [R23]
            end
            SSAR_RST_RUN:
            begin
                if (rst_cause)
                    next_rst_state = SSAR_RST_HOLD; // [R15]
            end
            default:
            begin
                next_rst_state = SSAR_RST_HOLD;
                next_tmr = '0;
            end
        endcase
    end

    // Battery test runs only while the power-up reset is held
    always_comb
    begin
        next_battery_low_n = battery_low_n;
        next_check_done = check_done;
        // A check result landing with a release wins that cycle
        if (!check_done && rst_state == SSAR_RST_WAIT && tmr_done)
        begin
            next_check_done = 1'b1; // [R13]
            next_battery_low_n = ~bat_low; // [R14]
        end
        else if (cmp.main_below_bat_release)
        begin
            next_battery_low_n = 1'b1; // [R14]
            next_check_done = 1'b0;
        end
    end

    always_comb
    begin
        next_sw.supply_from_battery = on_battery; // [R19]
        next_sw.supply_on = !(alarm && variant != SSAR_VAR_A); // [R12]
        next_sw.supply_hiz = alarm && variant == SSAR_VAR_B; // [R12]
        next_sw.supply_ground = alarm && variant == SSAR_VAR_C; // [R12]
        next_sw.ref_enable = !cmp.main_below_switch && !cmp.main_above_ref_max; // [R18]
    end

    wire next_src_n = on_battery | (alarm & (variant != SSAR_VAR_A)); // [R10] [R11]
    // Comparator disabled on battery keeps output low
    wire next_pfo_n = ~(cmp.pfi_below | cmp.main_below_switch | on_battery); // [R17] [R21]

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_state <= SSAR_RST_HOLD;
            tmr <= '0;
            check_done <= 1'b0;
            battery_low_n <= 1'b1;
            security_alarm_n <= 1'b0;
            reset_n <= 1'b0;
            power_fail_out_n <= 1'b0;
            supply_source_n <= 1'b1;
            sw_out <= '0;
        end
        else
        begin
            rst_state <= next_rst_state;
            tmr <= next_tmr;
            check_done <= next_check_done;
            battery_low_n <= next_battery_low_n;
            security_alarm_n <= ~alarm; // [R1] [R2] [R3] [R4] [R5]
            reset_n <= (next_rst_state == SSAR_RST_RUN); // [R15] [R16]
            power_fail_out_n <= next_pfo_n;
            supply_source_n <= next_src_n;
            sw_out <= next_sw;
        end
    end

    // APB slave, zero wait states
    wire apb_access = psel & penable;
    wire hit_ctrl = (paddr == REG_CTRL);
    wire hit_status = (paddr == REG_STATUS);
    wire hit_sense = (paddr == REG_SENSE);
    wire hit_any = hit_ctrl | hit_status | hit_sense;
    wire [31:0] status_word = {22'h0, rst_state, check_done, battery_low_n,
        supply_source_n, power_fail_out_n, reset_n, security_alarm_n, alarm};
    wire [31:0] sense_word = {11'h0, sync_b};
    wire [31:0] read_mux = hit_ctrl ? {25'h0, ctrl} :
        hit_status ? status_word : hit_sense ? sense_word : 32'h0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= CTRL_RESET;
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~hit_any;
            if (psel && !penable && !pwrite)
                prdata <= read_mux;
            if (apb_access && pwrite && hit_ctrl)
                ctrl <= pwdata[6:0];
        end
    end
endmodule

`default_nettype wire

/* File: sim/ssar_partner.sv */
// Tamper loops and reset button around the supervisor
`timescale 1ns/1ns
`default_nettype none
module ssar_partner
(
    input wire logic [3:0] cut,
    input wire logic press,
    output logic tamper_in_1,
    output logic tamper_in_2,
    output logic tamper_in_3,
    output logic tamper_in_4,
    output logic manual_reset_n
);
    // A cut loop lets the resistor win
    assign tamper_in_1 = !cut[0];
    assign tamper_in_2 = cut[1];
    assign tamper_in_3 = !cut[2];
    assign tamper_in_4 = cut[3];
    assign manual_reset_n = !press;
endmodule
`default_nettype wire

/* File: sim/ssar_checker.sv */
// Port assertions for the supervisor
`timescale 1ns/1ns
`default_nettype none
module ssar_checker
    import ssar_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire ssar_cmp_s cmp_in,
    input wire logic tamper_in_1,
    input wire logic tamper_in_2,
    input wire logic manual_reset_n,
    input wire logic security_alarm_n,
    input wire logic reset_n,
    input wire logic power_fail_out_n,
    input wire logic supply_source_n,
    input wire ssar_sw_s sw_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Three edges cover the synchronizer and output flop
    tamp_high_a: assert property (!tamper_in_1 [*3] |=> !security_alarm_n)
        else $error("tamper one low without alarm");
    tamp_low_a: assert property (tamper_in_2 [*3] |=> !security_alarm_n)
        else $error("tamper two high without alarm");
    volt_over_a: assert property (cmp_in.int_over_upper [*3] |=> !security_alarm_n)
        else $error("over voltage without alarm");
    volt_under_a: assert property (cmp_in.int_under_lower [*3] |=> !security_alarm_n)
        else $error("under voltage without alarm");
    man_reset_a: assert property (!manual_reset_n [*3] |=> !reset_n)
        else $error("manual reset not seen");
    rst_stretch_a: assert property ($rose(reset_n) |-> $past(manual_reset_n, 8))
        else $error("reset released too early");
    pf_in_a: assert property (cmp_in.pfi_below [*3] |=> !power_fail_out_n)
        else $error("power fail not flagged");
    ref_off_a: assert property (cmp_in.main_below_switch [*3] |=> !sw_out.ref_enable)
        else $error("reference left on");
    cut_alarm_a: assert property (sw_out.supply_hiz || sw_out.supply_ground |->
        !security_alarm_n || !$past(security_alarm_n))
        else $error("supply cut without alarm");
    src_main_a: assert property (!supply_source_n |-> !sw_out.supply_from_battery)
        else $error("indicator low on battery");
    cover property (!security_alarm_n ##1 security_alarm_n);
    cover property ($rose(reset_n));
    cover property (sw_out.supply_ground);
endmodule
bind ssar_top ssar_checker chk_u (.pclk, .presetn, .cmp_in, .tamper_in_1, .tamper_in_2,
    .manual_reset_n, .security_alarm_n, .reset_n, .power_fail_out_n, .supply_source_n, .sw_out);
`default_nettype wire

/* File: sim/tb_ssar_top.sv */
// Self-checking bench for the supervisor
`timescale 1ns/1ns
`default_nettype none
module tb_ssar_top
    import ssar_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, press = 0, err;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, tamper_in_1, tamper_in_2, tamper_in_3, tamper_in_4, manual_reset_n;
    logic security_alarm_n, reset_n, power_fail_out_n, battery_low_n, supply_source_n;
    logic [3:0] cut = 4'h0;
    ssar_cmp_s cmp_in = '0;
    ssar_sw_s sw_out;
    int n_fail = 0, n_checks = 0;
    always #50 pclk = !pclk;
    ssar_partner part_u (.cut, .press, .tamper_in_1, .tamper_in_2, .tamper_in_3, .tamper_in_4,
        .manual_reset_n);
    ssar_top #(.TIMEOUT_CYCLES(20)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cmp_in, .tamper_in_1, .tamper_in_2, .tamper_in_3,
        .tamper_in_4, .manual_reset_n, .security_alarm_n, .reset_n, .power_fail_out_n,
        .battery_low_n, .supply_source_n, .sw_out);
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic hang(input int k);
        if (k >= 50)
        begin
            n_fail++;
            give_verdict();
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        hang(k);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task automatic wait_rst();
        int k;
        k = 0;
        while (reset_n !== 1'b1 && k < 50)
        begin
            tick(1);
            k++;
        end
        hang(k);
    endtask
    function automatic logic [2:0] exp_sw(input int v);
        return (v == 0) ? 3'h4 : (v == 1) ? 3'h2 : 3'h1;
    endfunction
    function automatic logic temp_alarm(input int s, input int up, input int lo);
        return up > ((s % 4) > 2 ? 2 : s % 4) || lo > s / 4;
    endfunction
    initial
    begin
        int up, lo, v;
        void'($urandom(90235));
        cmp_in.bat_below_23 <= 1;
        tick(10);
        presetn <= 1;
        wait_rst();
        check(battery_low_n, 0);
        cmp_in.bat_below_23 <= 0;
        cmp_in.main_below_bat_release <= 1;
        tick(4);
        check(battery_low_n, 1);
        cmp_in.main_below_bat_release <= 0;
        for (int i = 0; i < 4; i++)
        begin
            cut <= 4'h1 << i;
            tick(4);
            check(security_alarm_n, 0);
            cut <= 4'h0;
            tick(4);
            check(security_alarm_n, 1);
        end
        for (v = 0; v < 3; v++)
        begin
            apb(1, REG_CTRL, v);
            cmp_in.int_over_upper <= (v != 1);
            cmp_in.int_under_lower <= (v == 1);
            tick(4);
            check(security_alarm_n, 0);
            check(supply_source_n, v != 0);
            check({sw_out.supply_on, sw_out.supply_hiz, sw_out.supply_ground}, exp_sw(v));
            cmp_in.int_over_upper <= 0;
            cmp_in.int_under_lower <= 0;
            tick(4);
            check(supply_source_n, 0);
        end
        apb(1, REG_CTRL, 0);
        cmp_in.main_below_switch <= 1;
        cmp_in.main_below_backup <= 1;
        cut <= 4'h2;
        tick(4);
        check({supply_source_n, power_fail_out_n, sw_out[1:0]}, 4'h8);
        check({security_alarm_n, sw_out.supply_from_battery}, 2'h1);
        cut <= 4'h0;
        cmp_in.main_below_switch <= 0;
        cmp_in.main_below_backup <= 0;
        cmp_in.pfi_below <= 1;
        tick(4);
        check({power_fail_out_n, sw_out.ref_enable}, 2'h1);
        cmp_in.pfi_below <= 0;
        for (int i = 0; i < 12; i++)
        begin
            up = $urandom_range(3);
            lo = $urandom_range(2);
            v = $urandom_range(7);
            apb(1, REG_CTRL, v << 2);
            cmp_in.temp_over_80 <= up > 0;
            cmp_in.temp_over_85 <= up > 1;
            cmp_in.temp_over_95 <= up > 2;
            cmp_in.temp_under_25 <= lo > 0;
            cmp_in.temp_under_35 <= lo > 1;
            tick(4);
            check(security_alarm_n, !temp_alarm(v, up, lo));
        end
        cmp_in <= '0;
        for (int c = 0; c < 2; c++)
        begin
            press <= (c == 0);
            cmp_in.main_below_reset <= (c == 1);
            tick(4);
            check(reset_n, 0);
            press <= 0;
            cmp_in.main_below_reset <= 0;
            tick(18);
            check(reset_n, 0);
            tick(10);
            check(reset_n, 1);
        end
        apb(0, 8'h0c, 0);
        check(err, 1);
        check(rd, 0);
        give_verdict();
    end
endmodule
`default_nettype wire
